// *** design/pmt_pkg.sv ***
// Package for the 8-bit period match timer: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package pmt_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PMT_IDX_COUNT = 8'h11;
  localparam logic [7:0] PMT_IDX_CTRL = 8'h12;
  localparam logic [7:0] PMT_IDX_PERIOD = 8'h13;
  localparam logic [7:0] PMT_IDX_STATUS = 8'h14;
  localparam logic [7:0] PMT_IDX_MASK = 8'h15;
  localparam int PMT_ADDR_W = 12;
  // Byte address is four times the index
  localparam logic [PMT_ADDR_W-1:0] PMT_ADDR_COUNT = {2'h0, PMT_IDX_COUNT, 2'h0};
  localparam logic [PMT_ADDR_W-1:0] PMT_ADDR_CTRL = {2'h0, PMT_IDX_CTRL, 2'h0};
  localparam logic [PMT_ADDR_W-1:0] PMT_ADDR_PERIOD = {2'h0, PMT_IDX_PERIOD, 2'h0};
  localparam logic [PMT_ADDR_W-1:0] PMT_ADDR_STATUS = {2'h0, PMT_IDX_STATUS, 2'h0};
  localparam logic [PMT_ADDR_W-1:0] PMT_ADDR_MASK = {2'h0, PMT_IDX_MASK, 2'h0};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PMT_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
  localparam logic [7:0] PMT_CTRL_RST = 8'h00;
  localparam logic [7:0] PMT_STATUS_RST = 8'h00;
  localparam logic [7:0] PMT_MASK_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and constants
  // ----------------------------------------------------------------
  localparam int PMT_MATCH_FLAG_BIT = 0;
  localparam logic [1:0] PMT_INSTR_DIV_LAST = 2'h3;
  localparam logic [3:0] PMT_PRE_LIMIT_1 = 4'h0;
  localparam logic [3:0] PMT_PRE_LIMIT_4 = 4'h3;
  localparam logic [3:0] PMT_PRE_LIMIT_16 = 4'hF;
  localparam logic [1:0] PMT_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMT_RESP_SLVERR = 2'h2;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic spare;
    logic [3:0] postscale_sel;
    logic run_bit;
    logic [1:0] prescale_sel;
  } pmt_ctrl_t;

  // One AXI4-Lite response as carried on a channel
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
  } pmt_rsp_t;

endpackage : pmt_pkg

// *** design/pmt_timer.sv ***
// Period match timer with AXI4-Lite register access and a level interrupt.
// Assumes aclk is the system clock; the instruction clock is made inside.
`timescale 1ns/100ps

module pmt_timer
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [PMT_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [PMT_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] instr_div_reg;
  logic [3:0] pre_cnt_reg;
  logic [3:0] post_cnt_reg;
  logic [7:0] count_reg;
  logic [7:0] period_reg;
  pmt_ctrl_t ctrl_reg;
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic irq_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [PMT_ADDR_W-1:0] waddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  pmt_rsp_t rsp_reg;
  logic [7:0] count_next;
  logic [3:0] pre_cnt_next;
  logic [3:0] post_cnt_next;
  logic [7:0] status_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire aw_fire = awvalid && awready_reg;
  wire w_fire = wvalid && wready_reg;
  wire ar_fire = arvalid && arready_reg;
  wire wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
  wire aw_full_next = (aw_full_reg || aw_fire) && !wr_do;
  wire w_full_next = (w_full_reg || w_fire) && !wr_do;
  wire wr_en = wr_do && wlane_reg;
  wire wsel_count = waddr_reg == PMT_ADDR_COUNT;
  wire wsel_ctrl = waddr_reg == PMT_ADDR_CTRL;
  wire wsel_period = waddr_reg == PMT_ADDR_PERIOD;
  wire wsel_status = waddr_reg == PMT_ADDR_STATUS;
  wire wsel_mask = waddr_reg == PMT_ADDR_MASK;
  wire wmapped = wsel_count || wsel_ctrl || wsel_period || wsel_status || wsel_mask;
  wire rsel_count = araddr == PMT_ADDR_COUNT;
  wire rsel_ctrl = araddr == PMT_ADDR_CTRL;
  wire rsel_period = araddr == PMT_ADDR_PERIOD;
  wire rsel_status = araddr == PMT_ADDR_STATUS;
  wire rsel_mask = araddr == PMT_ADDR_MASK;
  wire rmapped = rsel_count || rsel_ctrl || rsel_period || rsel_status || rsel_mask;
  // Read mux; bit 7 of control reads as zero
  wire [7:0] read_byte = rsel_count ? count_reg :
                         rsel_ctrl ? {1'b0, ctrl_reg[6:0]} :
                         rsel_period ? period_reg :
                         rsel_status ? status_reg :
                         rsel_mask ? mask_reg : 8'h00;

  // ----------------------------------------------------------------
  // Timer datapath
  // ----------------------------------------------------------------
  wire run = ctrl_reg.run_bit;
  // Instruction clock strobe, one system cycle in four
  wire instr_tick = instr_div_reg == PMT_INSTR_DIV_LAST;
  // Prescale ratio: 1, 4, or 16 when the upper bit is set
  wire [3:0] pre_limit = ctrl_reg.prescale_sel[1] ? PMT_PRE_LIMIT_16 :
                         ctrl_reg.prescale_sel[0] ? PMT_PRE_LIMIT_4 :
                         PMT_PRE_LIMIT_1;
  wire pre_pulse = run && instr_tick && (pre_cnt_reg == pre_limit);
  wire match = count_reg == period_reg;
  wire wrap_pulse = pre_pulse && match;
  wire post_hit = post_cnt_reg == ctrl_reg.postscale_sel;
  wire post_out = wrap_pulse && post_hit;
  wire cnt_wr = wr_en && wsel_count && run;
  wire irq_next = |(status_next & mask_reg);

  // Next count: stop clears, bus write, then increment or wrap
  always_comb
  begin
    count_next = count_reg;
    if (!run)
      count_next = PMT_COUNT_RST;
    else if (cnt_wr)
      count_next = wbyte_reg;
    else if (pre_pulse)
      count_next = match ? PMT_COUNT_RST : count_reg + 8'h01;
  end

  // Next prescaler and postscaler counts
  always_comb
  begin
    pre_cnt_next = pre_cnt_reg;
    post_cnt_next = post_cnt_reg;
    if (!run)
    begin
      pre_cnt_next = 4'h0;
      post_cnt_next = 4'h0;
    end
    else
    begin
      if (instr_tick)
        pre_cnt_next = pre_pulse ? 4'h0 : pre_cnt_reg + 4'h1;
      if (wrap_pulse)
        post_cnt_next = post_hit ? 4'h0 : post_cnt_reg + 4'h1;
    end
  end

  // Sticky flags: a set in the same cycle beats a write-one clear
  always_comb
  begin
    status_next = status_reg;
    if (wr_en && wsel_status)
      status_next = status_reg & ~wbyte_reg;
    if (post_out)
      status_next[PMT_MATCH_FLAG_BIT] = 1'b1;
  end

  // Instruction clock divider runs freely
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr_div_reg <= 2'h0;
    else
      instr_div_reg <= instr_div_reg + 2'h1;
  end

  // Timer counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= PMT_COUNT_RST;
      pre_cnt_reg <= 4'h0;
      post_cnt_reg <= 4'h0;
    end
    else
    begin
      count_reg <= count_next;
      pre_cnt_reg <= pre_cnt_next;
      post_cnt_reg <= post_cnt_next;
    end
  end

  // Software registers; a control write leaves the count alone unless it clears run_bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_reg <= PMT_PERIOD_RST;
      ctrl_reg <= PMT_CTRL_RST;
      status_reg <= PMT_STATUS_RST;
      mask_reg <= PMT_MASK_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && wsel_period)
        period_reg <= wbyte_reg;
      if (wr_en && wsel_ctrl)
        ctrl_reg <= {1'b0, wbyte_reg[6:0]};
      if (wr_en && wsel_mask)
        mask_reg <= wbyte_reg;
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are held independently until both are present
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      waddr_reg <= '0;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= PMT_RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg <= !w_full_next;
      if (aw_fire)
        waddr_reg <= awaddr;
      if (w_fire)
      begin
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
      if (wr_do)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wmapped ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
      end
      else if (bvalid_reg && bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // One read at a time; address ready drops while data is offered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rsp_reg <= '0;
    end
    else if (ar_fire)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rsp_reg.data <= {24'h000000, read_byte};
      rsp_reg.resp <= rmapped ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
    end
    else if (rvalid_reg && rready)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
    else
      arready_reg <= !rvalid_reg;
  end

  // Outputs straight from flip-flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rsp_reg.data;
  assign rresp = rsp_reg.resp;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_instr_tick;
    @(posedge aclk) disable iff (!aresetn)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick;
  endproperty
  a_instr_tick: assert property (p_instr_tick)
    else $error("instruction strobe not one in four");

  property p_count_incr;
    @(posedge aclk) disable iff (!aresetn)
    (run && pre_pulse && !match && !cnt_wr && $past(aresetn)) ##1 run
      |-> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_count_incr: assert property (p_count_incr)
    else $error("count did not increment");

  property p_match_wrap;
    @(posedge aclk) disable iff (!aresetn)
    (wrap_pulse && !cnt_wr) |=> count_reg == 8'h00;
  endproperty
  a_match_wrap: assert property (p_match_wrap)
    else $error("count did not return to zero on match");

  property p_post_step;
    @(posedge aclk) disable iff (!aresetn)
    (wrap_pulse && !post_hit) |=> post_cnt_reg == $past(post_cnt_reg) + 4'h1;
  endproperty
  a_post_step: assert property (p_post_step)
    else $error("postscaler did not advance");

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    post_out |=> status_reg[PMT_MATCH_FLAG_BIT] ##1 irq == mask_reg[PMT_MATCH_FLAG_BIT] || !irq;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("match flag not set by postscaler");

  property p_flag_sticky;
    @(posedge aclk) disable iff (!aresetn)
    status_reg[PMT_MATCH_FLAG_BIT] && !(wr_en && wsel_status) |=> status_reg[PMT_MATCH_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("match flag dropped without clear");

  property p_reset_vals;
    @(posedge aclk)
    !aresetn |=> count_reg == 8'h00 && period_reg == 8'hFF && pre_cnt_reg == 4'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");

  property p_stop_clear;
    @(posedge aclk) disable iff (!aresetn)
    !run |=> count_reg == 8'h00 && pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("counters not cleared while stopped");

  property p_ctrl_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wsel_ctrl && run && !pre_pulse) |=> count_reg == $past(count_reg);
  endproperty
  a_ctrl_keeps: assert property (p_ctrl_keeps)
    else $error("control write changed count");

  property p_pre_ratio;
    @(posedge aclk) disable iff (!aresetn)
    pre_pulse |-> (ctrl_reg.prescale_sel == 2'h0) ||
      (ctrl_reg.prescale_sel == 2'h1 && pre_cnt_reg == 4'h3) ||
      (ctrl_reg.prescale_sel[1] && pre_cnt_reg == 4'hF);
  endproperty
  a_pre_ratio: assert property (p_pre_ratio)
    else $error("prescale pulse at wrong count");

  property p_post_ratio;
    @(posedge aclk) disable iff (!aresetn)
    post_out |-> post_cnt_reg == ctrl_reg[6:3] ##1 post_cnt_reg == 4'h0 || !run;
  endproperty
  a_post_ratio: assert property (p_post_ratio)
    else $error("postscale ratio wrong");

  property p_spare_zero;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_reg.spare == 1'b0;
  endproperty
  a_spare_zero: assert property (p_spare_zero)
    else $error("control bit seven stored");

  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) wrap_pulse);
  c_flag: cover property (@(posedge aclk) disable iff (!aresetn) post_out ##[1:8] irq);
  c_set_vs_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    post_out && wr_en && wsel_status);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready);

endmodule : pmt_timer

// *** testbench/pmt_timer_test.sv ***
// Self-checking bench for the period match timer, driven over AXI4-Lite.
// Assumes the design checks its own properties; this file only drives and compares.
`timescale 1ns/100ps

module pmt_timer_test;
  import pmt_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------
  localparam int LIMIT = 50000;
  logic aclk, aresetn, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [PMT_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0] bresp, rresp, rd_rsp;
  int failures, cmp_count, cyc;

  pmt_timer i_pmt_timer (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));

  // ----------------------------------------------------------------
  // Clock, cycle count and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Cut a hang short and report it
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  // One write: address and data together, then wait for the response
  task automatic wr(input logic [PMT_ADDR_W-1:0] a, input logic [7:0] v, input logic [1:0] er);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h000000, v};
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge aclk);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr

  // One read: result left in rd_val and rd_rsp
  task automatic rd(input logic [PMT_ADDR_W-1:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_val = rdata;
    rd_rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [PMT_ADDR_W-1:0] a, input logic [7:0] exp);
    rd(a);
    check(rd_val, {24'h000000, exp}, "read data");
    check({30'h0, rd_rsp}, {30'h0, PMT_RESP_OKAY}, "read response");
  endtask : rd_chk

  task automatic wait_irq(input logic v);
    do @(posedge aclk); while (irq !== v);
  endtask : wait_irq

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(PMT_ADDR_COUNT, PMT_COUNT_RST);
    rd_chk(PMT_ADDR_PERIOD, PMT_PERIOD_RST);
    rd_chk(PMT_ADDR_CTRL, PMT_CTRL_RST);
    rd_chk(PMT_ADDR_STATUS, PMT_STATUS_RST);
    rd_chk(PMT_ADDR_MASK, PMT_MASK_RST);
    rd(12'h000);
    check(rd_val, 32'h0, "unmapped read data");
    check({30'h0, rd_rsp}, {30'h0, PMT_RESP_SLVERR}, "unmapped read response");
    wr(12'h000, 8'hAA, PMT_RESP_SLVERR);
  endtask : t_reset

  // Spare bit, and a stopped timer holding its count at zero
  task automatic t_stopped;
    wr(PMT_ADDR_CTRL, 8'hFB, PMT_RESP_OKAY);
    rd_chk(PMT_ADDR_CTRL, 8'h7B);
    wr(PMT_ADDR_COUNT, 8'h55, PMT_RESP_OKAY);
    rd_chk(PMT_ADDR_COUNT, 8'h00);
    repeat (100) @(posedge aclk);
    rd_chk(PMT_ADDR_COUNT, 8'h00);
    rd_chk(PMT_ADDR_STATUS, 8'h00);
    wr(PMT_ADDR_CTRL, 8'h00, PMT_RESP_OKAY);
  endtask : t_stopped

  // Count write while running, control write keeping the count, stop clearing it
  task automatic t_count;
    logic [31:0] c1;
    wr(PMT_ADDR_CTRL, 8'h07, PMT_RESP_OKAY);
    wr(PMT_ADDR_COUNT, 8'h80, PMT_RESP_OKAY);
    rd(PMT_ADDR_COUNT);
    check(32'(rd_val == 32'h80 || rd_val == 32'h81), 32'h1, "count write");
    c1 = rd_val;
    wr(PMT_ADDR_CTRL, 8'h07, PMT_RESP_OKAY);
    rd(PMT_ADDR_COUNT);
    check(32'(rd_val == c1 || rd_val == c1 + 1), 32'h1, "count after ctrl write");
    wr(PMT_ADDR_CTRL, 8'h00, PMT_RESP_OKAY);
    repeat (2) @(posedge aclk);
    rd_chk(PMT_ADDR_COUNT, 8'h00);
  endtask : t_count

  // Count never passes the period; flag stays set while masked and stopped
  task automatic t_sticky;
    wr(PMT_ADDR_MASK, 8'h00, PMT_RESP_OKAY);
    wr(PMT_ADDR_PERIOD, 8'h03, PMT_RESP_OKAY);
    wr(PMT_ADDR_CTRL, 8'h04, PMT_RESP_OKAY);
    repeat (8)
    begin
      rd(PMT_ADDR_COUNT);
      check(32'(rd_val <= 32'h3), 32'h1, "count above period");
    end
    repeat (100) @(posedge aclk);
    check({31'h0, irq}, 32'h0, "masked irq");
    wr(PMT_ADDR_CTRL, 8'h00, PMT_RESP_OKAY);
    rd_chk(PMT_ADDR_STATUS, 8'h01);
    wr(PMT_ADDR_STATUS, 8'h01, PMT_RESP_OKAY);
    rd_chk(PMT_ADDR_STATUS, 8'h00);
  endtask : t_sticky

  // Exact spacing of two flag events for one prescale and postscale setting
  task automatic t_rate(input logic [7:0] cfg, input int exp);
    int t1;
    wr(PMT_ADDR_CTRL, 8'h00, PMT_RESP_OKAY);
    wr(PMT_ADDR_STATUS, 8'h01, PMT_RESP_OKAY);
    wr(PMT_ADDR_CTRL, cfg | 8'h04, PMT_RESP_OKAY);
    wait_irq(1'b1);
    t1 = cyc;
    wr(PMT_ADDR_STATUS, 8'h01, PMT_RESP_OKAY);
    wait_irq(1'b0);
    wait_irq(1'b1);
    check(32'(cyc - t1), 32'(exp), "match interval");
  endtask : t_rate

  // Reset in mid-run returns count, period, control and status to their reset values
  task automatic t_midreset;
    wr(PMT_ADDR_PERIOD, 8'h10, PMT_RESP_OKAY);
    repeat (40) @(posedge aclk);
    check({31'h0, irq}, 32'h1, "irq before reset");
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(PMT_ADDR_COUNT, PMT_COUNT_RST);
    rd_chk(PMT_ADDR_PERIOD, PMT_PERIOD_RST);
    rd_chk(PMT_ADDR_CTRL, PMT_CTRL_RST);
    rd_chk(PMT_ADDR_STATUS, PMT_STATUS_RST);
    check({31'h0, irq}, 32'h0, "irq after reset");
  endtask : t_midreset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_stopped();
    t_count();
    t_sticky();
    wr(PMT_ADDR_MASK, 8'h01, PMT_RESP_OKAY);
    t_rate(8'h00, 16);
    t_rate(8'h01, 64);
    t_rate(8'h02, 256);
    t_rate(8'h03, 256);
    for (int p = 1; p < 16; p++)
      t_rate(8'(p << 3), 16 * (p + 1));
    t_midreset();
    conclude();
  end

endmodule : pmt_timer_test
